// ===== cei_params.svh
// Purpose: Offsets, field positions, reset values and limits of the error block
// Assumes: 32-bit register port, byte addresses
// Notes:   Included by the design and the test bench
`ifndef CEI_PARAMS_SVH
`define CEI_PARAMS_SVH
`define CEI_OFF_CTRL      8'h00
`define CEI_OFF_GIE       8'h04
`define CEI_OFF_GFL       8'h08
`define CEI_OFF_CIE       8'h0C
`define CEI_OFF_CFL       8'h10
`define CEI_OFF_TXF       8'h14
`define CEI_OFF_STS       8'h18
`define CEI_OFF_CNT       8'h1C
`define CEI_CTRL_RST      8'h01
`define CEI_CTRL_BOM      3:2
`define CEI_CTRL_ERROR_INDICATION_SELECT     4
`define CEI_CTRL_FORCE_BUSOFF_EXIT     5
`define CEI_CTRL_DLCE     6
`define CEI_CTRL_TAIE     7
`define CEI_CF_BUS        0
`define CEI_CF_WARN       1
`define CEI_CF_PASS       2
`define CEI_CF_BOE        3
`define CEI_CF_BOR        4
`define CEI_CF_OVLD       5
`define CEI_CF_LOCK       6
`define CEI_CF_ARB        7
`define CEI_CF_BERR       14:8
`define CEI_CF_CEO        15
`define CEI_CF_SCO        16
`define CEI_CF_TDC        17
`define CEI_CF_W          18
`define CEI_WARN_LIM      9'd95
`define CEI_PASS_LIM      9'd127
`define CEI_BOFF_LIM      9'd255
`define CEI_RECOV_SEQ     8'd128
`define CEI_LOCK_BITS     6'd32
`define CEI_CTR_MAX       8'hFF
`define CEI_TDC_BITS      10'd6
`define CEI_TDC_CLKS      10'd2
`endif

// ===== cei_pkg.sv
// Purpose: Types shared by the error and interrupt block
// Assumes: Enum values are literals here; cei_params.svh is not included
// Notes:   Nothing here is imported
`default_nettype none
package cei_pkg;
	typedef enum logic [1:0]
	{
		CEI_MD_OP    = 2'b00,
		CEI_MD_RESET = 2'b01,
		CEI_MD_HALT  = 2'b10
	} cei_mode_t;
	typedef enum logic [1:0]
	{
		CEI_BO_STD   = 2'b00,
		CEI_BO_ENTRY = 2'b01,
		CEI_BO_END   = 2'b10,
		CEI_BO_SW    = 2'b11
	} cei_bom_t;
	typedef struct packed
	{
		logic [7:0]  addr;
		logic [31:0] wdata;
		logic        wr;
		logic        rd;
	} cei_req_t;
	typedef struct packed
	{
		logic       done;
		logic [3:0] dlc;
		logic [3:0] rule_dlc;
		logic [6:0] len;
		logic [6:0] buf_size;
	} cei_rx_t;
endpackage
`default_nettype wire

// ===== cei_core.sv
// Purpose: Error detection, interrupt requests and bus-off handling of one channel
// Assumes: Event inputs are one-cycle pulses from logic on clk; rx_pin is asynchronous
// Notes:   Flags are write-one-to-clear; a set in the same cycle wins
`include "cei_params.svh"
`default_nettype none

module cei_core
(
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             rst_n,
	// Register port
	input  wire cei_pkg::cei_req_t req,
	output logic [31:0]           rdata,
	// Receive path
	input  wire cei_pkg::cei_rx_t rx,
	input  wire logic             fifo_full_store,
	input  wire logic             hist_full_store,
	// Protocol engine
	input  wire logic [6:0]       bus_err,
	input  wire logic             err_qualify,
	input  wire logic             frame_done,
	input  wire logic [8:0]       tec,
	input  wire logic [8:0]       rec,
	input  wire logic             rec11_evt,
	input  wire logic             bit_tick,
	input  wire logic             rx_pin,
	input  wire logic             overload,
	input  wire logic             arb_lost,
	input  wire logic             tdc_valid,
	input  wire logic [9:0]       tdc_meas,
	input  wire logic [9:0]       dbit_clks,
	// Transmit sources
	input  wire logic             abort_done,
	input  wire logic             tx_done_irq,
	input  wire logic             cf_tx_irq,
	input  wire logic             hist_irq,
	// Interrupts and state
	output logic                  irq_global,
	output logic                  irq_chan_err,
	output logic                  irq_tx,
	output cei_pkg::cei_mode_t    mode,
	output logic                  bus_off
);
	////////////////////////////////////////////////////////////////////////////////
	// Register decode
	logic [7:0]               ctrl_q;
	logic [3:0]               gie_q;
	logic [3:0]               gfl_q;
	logic [`CEI_CF_W-1:0]     cie_q;
	logic [`CEI_CF_W-1:0]     cfl_q;
	logic                     txf_q;
	logic [7:0]               rcnt_q;
	logic [7:0]               cec_q;
	logic [7:0]               scc_q;
	logic [5:0]               lock_q;
	logic                     warn_seen_q;
	logic                     pass_seen_q;
	logic                     pend_halt_q;
	logic                     no_rirq_q;
	logic                     rx_meta_q;
	logic                     rx_sync_q;
	cei_pkg::cei_mode_t       mode_q;
	logic                     boff_q;
	logic [31:0]              rdata_q;

	wire wr_ctrl = req.wr && req.addr == `CEI_OFF_CTRL;
	wire wr_gie  = req.wr && req.addr == `CEI_OFF_GIE;
	wire wr_gfl  = req.wr && req.addr == `CEI_OFF_GFL;
	wire wr_cie  = req.wr && req.addr == `CEI_OFF_CIE;
	wire wr_cfl  = req.wr && req.addr == `CEI_OFF_CFL;
	wire wr_txf  = req.wr && req.addr == `CEI_OFF_TXF;
	wire cei_pkg::cei_mode_t req_mode = cei_pkg::cei_mode_t'(
		req.wdata[1:0] == 2'b11 ? 2'b01 : req.wdata[1:0]);
	wire cei_pkg::cei_bom_t busoff_behaviour_select = cei_pkg::cei_bom_t'(ctrl_q[`CEI_CTRL_BOM]);
	wire force_exit = wr_ctrl && req.wdata[`CEI_CTRL_FORCE_BUSOFF_EXIT];

	////////////////////////////////////////////////////////////////////////////////
	// Global error sources
	wire dlc_fail = rx.done && ctrl_q[`CEI_CTRL_DLCE] && rx.dlc < rx.rule_dlc;
	wire pay_ovf  = rx.done && !dlc_fail && rx.len > rx.buf_size;
	wire [3:0] gset = {pay_ovf, hist_full_store, fifo_full_store, dlc_fail};
	wire [3:0] gfl_d = (gfl_q & ~(wr_gfl ? req.wdata[3:0] : 4'h0)) | gset;

	////////////////////////////////////////////////////////////////////////////////
	// Channel error sources
	wire [6:0] berr_now = cfl_q[`CEI_CF_BERR];
	wire [6:0] berr_set = (ctrl_q[`CEI_CTRL_ERROR_INDICATION_SELECT] || berr_now == 7'h00) ? bus_err : 7'h00;
	wire any_berr  = |bus_err;
	wire warn_cond = tec > `CEI_WARN_LIM || rec > `CEI_WARN_LIM;
	wire pass_cond = tec > `CEI_PASS_LIM || rec > `CEI_PASS_LIM;
	wire warn_evt  = warn_cond && !warn_seen_q;
	wire pass_evt  = pass_cond && !pass_seen_q;
	wire bo_entry  = tec > `CEI_BOFF_LIM && !boff_q;
	wire recov_end = boff_q && rec11_evt && rcnt_q == `CEI_RECOV_SEQ - 8'd1;
	wire bo_cancel = wr_ctrl && (req_mode == cei_pkg::CEI_MD_RESET || (req_mode ==
		cei_pkg::CEI_MD_HALT && busoff_behaviour_select == cei_pkg::CEI_BO_SW));
	wire recov_irq = recov_end && busoff_behaviour_select != cei_pkg::CEI_BO_ENTRY && !no_rirq_q && !bo_cancel;
	wire lock_evt  = mode_q == cei_pkg::CEI_MD_OP && bit_tick && !rx_sync_q &&
		lock_q == `CEI_LOCK_BITS - 6'd1;
	wire cec_ovf   = any_berr && err_qualify && cec_q == `CEI_CTR_MAX;
	wire scc_ovf   = frame_done && scc_q == `CEI_CTR_MAX;
	wire [9:0] tdc_max = dbit_clks * `CEI_TDC_BITS - `CEI_TDC_CLKS;
	wire tdc_evt   = tdc_valid && tdc_meas > tdc_max;

	wire [`CEI_CF_W-1:0] cset;
	assign cset[`CEI_CF_BUS]  = any_berr;
	assign cset[`CEI_CF_WARN] = warn_evt;
	assign cset[`CEI_CF_PASS] = pass_evt;
	assign cset[`CEI_CF_BOE]  = bo_entry;
	assign cset[`CEI_CF_BOR]  = recov_irq;
	assign cset[`CEI_CF_OVLD] = overload;
	assign cset[`CEI_CF_LOCK] = lock_evt;
	assign cset[`CEI_CF_ARB]  = arb_lost;
	assign cset[`CEI_CF_BERR] = berr_set;
	assign cset[`CEI_CF_CEO]  = cec_ovf;
	assign cset[`CEI_CF_SCO]  = scc_ovf;
	assign cset[`CEI_CF_TDC]  = tdc_evt;
	wire [`CEI_CF_W-1:0] cfl_d = (cfl_q & ~(wr_cfl ? req.wdata[`CEI_CF_W-1:0] :
		{`CEI_CF_W{1'b0}})) | cset;
	wire txf_d = (txf_q && !(wr_txf && req.wdata[0])) || abort_done;

	////////////////////////////////////////////////////////////////////////////////
	// Mode and bus-off control
	cei_pkg::cei_mode_t mode_d;
	logic               pend_halt_d;
	always_comb
	begin
		mode_d      = mode_q;
		pend_halt_d = pend_halt_q && boff_q && !recov_end;
		if (wr_ctrl)
		begin
			if (req_mode == cei_pkg::CEI_MD_HALT && boff_q && busoff_behaviour_select == cei_pkg::CEI_BO_STD)
				pend_halt_d = 1'b1;
			else
				mode_d = req_mode;
		end
		else if (bo_entry && busoff_behaviour_select == cei_pkg::CEI_BO_ENTRY && mode_q == cei_pkg::CEI_MD_OP)
			mode_d = cei_pkg::CEI_MD_HALT;
		else if (recov_end && (pend_halt_q || (busoff_behaviour_select == cei_pkg::CEI_BO_END &&
			mode_q == cei_pkg::CEI_MD_OP)))
			mode_d = cei_pkg::CEI_MD_HALT;
	end
	wire boff_clr = recov_end || force_exit || (wr_ctrl && req_mode == cei_pkg::CEI_MD_RESET);
	wire boff_d   = bo_entry || (boff_q && !boff_clr);
	wire in_reset = mode_q == cei_pkg::CEI_MD_RESET;

	////////////////////////////////////////////////////////////////////////////////
	// Read mux
	wire [31:0] sts_w = {20'h0_0000, lock_q == `CEI_LOCK_BITS, rcnt_q, boff_q, mode_q};
	wire [31:0] rd_w =
		req.addr == `CEI_OFF_CTRL ? {24'h0, ctrl_q} :
		req.addr == `CEI_OFF_GIE  ? {28'h0, gie_q} :
		req.addr == `CEI_OFF_GFL  ? {28'h0, gfl_q} :
		req.addr == `CEI_OFF_CIE  ? {14'h0, cie_q} :
		req.addr == `CEI_OFF_CFL  ? {14'h0, cfl_q} :
		req.addr == `CEI_OFF_TXF  ? {31'h0, txf_q} :
		req.addr == `CEI_OFF_STS  ? sts_w :
		req.addr == `CEI_OFF_CNT  ? {16'h0, scc_q, cec_q} : 32'h0000_0000;

	////////////////////////////////////////////////////////////////////////////////
	// Registers
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ctrl_q <= `CEI_CTRL_RST;
			gie_q  <= 4'h0;
			gfl_q  <= 4'h0;
			cie_q  <= {`CEI_CF_W{1'b0}};
			cfl_q  <= {`CEI_CF_W{1'b0}};
			txf_q  <= 1'b0;
			mode_q <= cei_pkg::CEI_MD_RESET;
			boff_q <= 1'b0;
			pend_halt_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
		end
		else
		begin
			if (wr_ctrl)
				ctrl_q <= {req.wdata[7:6], 1'b0, req.wdata[4:2], mode_d};
			else
				ctrl_q[1:0] <= mode_d;
			if (wr_gie)
				gie_q <= req.wdata[3:0];
			if (wr_cie)
				cie_q <= req.wdata[`CEI_CF_W-1:0];
			gfl_q  <= gfl_d;
			cfl_q  <= cfl_d;
			txf_q  <= txf_d;
			mode_q <= mode_d;
			boff_q <= boff_d;
			pend_halt_q <= pend_halt_d;
			rdata_q <= req.rd ? rd_w : 32'h0000_0000;
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rcnt_q      <= 8'h00;
			no_rirq_q   <= 1'b0;
			warn_seen_q <= 1'b0;
			pass_seen_q <= 1'b0;
			cec_q       <= 8'h00;
			scc_q       <= 8'h00;
		end
		else
		begin
			if (!boff_q || boff_clr)
				rcnt_q <= 8'h00;
			else if (rec11_evt)
				rcnt_q <= rcnt_q + 8'd1;
			no_rirq_q   <= boff_q && !boff_clr && (no_rirq_q || bo_cancel);
			warn_seen_q <= !in_reset && (warn_seen_q || warn_cond);
			pass_seen_q <= !in_reset && (pass_seen_q || pass_cond);
			if (any_berr && err_qualify && cec_q != `CEI_CTR_MAX)
				cec_q <= cec_q + 8'd1;
			if (frame_done && scc_q != `CEI_CTR_MAX)
				scc_q <= scc_q + 8'd1;
		end
	end

	// Bus line sampled through two flops before the dominant run counter
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rx_meta_q <= 1'b1;
			rx_sync_q <= 1'b1;
			lock_q    <= 6'd0;
		end
		else
		begin
			rx_meta_q <= rx_pin;
			rx_sync_q <= rx_meta_q;
			if (mode_q != cei_pkg::CEI_MD_OP || (bit_tick && rx_sync_q))
				lock_q <= 6'd0;
			else if (bit_tick && lock_q != `CEI_LOCK_BITS)
				lock_q <= lock_q + 6'd1;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Outputs
	assign rdata        = rdata_q;
	assign irq_global   = |(gfl_q & gie_q);
	assign irq_chan_err = |(cfl_q & cie_q);
	assign irq_tx = tx_done_irq || cf_tx_irq || hist_irq ||
		(txf_q && ctrl_q[`CEI_CTRL_TAIE]);
	assign mode    = mode_q;
	assign bus_off = boff_q;

	////////////////////////////////////////////////////////////////////////////////
	// Checks
	a_dlc_flag: assert property (@(posedge clk) disable iff (!rst_n)
		dlc_fail |=> gfl_q[0]) else $error("DLC error not flagged");
	a_pay_excl: assert property (@(posedge clk) disable iff (!rst_n)
		dlc_fail |-> !pay_ovf) else $error("Payload overflow with DLC error");
	a_flag_hold: assert property (@(posedge clk) disable iff (!rst_n)
		$past(cfl_q[`CEI_CF_BUS]) && !$past(wr_cfl) |-> cfl_q[`CEI_CF_BUS])
		else $error("Flag dropped without clear");
	a_set_wins: assert property (@(posedge clk) disable iff (!rst_n)
		wr_cfl && arb_lost |=> cfl_q[`CEI_CF_ARB]) else $error("Set lost to clear");
	a_irq_gate: assert property (@(posedge clk) disable iff (!rst_n)
		cie_q == {`CEI_CF_W{1'b0}} |-> !irq_chan_err) else $error("Masked irq");
	a_warn_once: assert property (@(posedge clk) disable iff (!rst_n)
		warn_evt |=> !warn_evt [*2]) else $error("Warning repeated");
	a_boff_enter: assert property (@(posedge clk) disable iff (!rst_n)
		tec > `CEI_BOFF_LIM && !boff_q |=> boff_q && cfl_q[`CEI_CF_BOE])
		else $error("Bus-off not entered");
	a_recov_end: assert property (@(posedge clk) disable iff (!rst_n)
		recov_end |=> !boff_q && (rcnt_q == 8'h00)) else $error("Recovery missed");
	a_halt_entry: assert property (@(posedge clk) disable iff (!rst_n)
		bo_entry && busoff_behaviour_select == cei_pkg::CEI_BO_ENTRY && mode_q == cei_pkg::CEI_MD_OP &&
		!wr_ctrl |=> mode_q == cei_pkg::CEI_MD_HALT) else $error("No halt at entry");
	a_no_bo01_irq: assert property (@(posedge clk) disable iff (!rst_n)
		busoff_behaviour_select == cei_pkg::CEI_BO_ENTRY |-> !recov_irq) else $error("Recovery irq in 01");
	a_defer_halt: assert property (@(posedge clk) disable iff (!rst_n)
		pend_halt_q && !recov_end |=> mode_q == $past(mode_q) || $past(wr_ctrl))
		else $error("Halt not deferred");
	a_first_err: assert property (@(posedge clk) disable iff (!rst_n)
		!ctrl_q[`CEI_CTRL_ERROR_INDICATION_SELECT] && berr_now != 7'h00 && !wr_cfl |=>
		cfl_q[`CEI_CF_BERR] == $past(berr_now)) else $error("Later error set");
	a_tdc_viol: assert property (@(posedge clk) disable iff (!rst_n)
		tdc_evt |=> cfl_q[`CEI_CF_TDC]) else $error("TDC violation missed");
endmodule
`default_nettype wire

// ===== cei_bus_node.sv
// Purpose: Other nodes on the shared bus: bit times, bus level, recessive runs
// Assumes: One nominal bit every BIT_CLKS clocks
// Notes:   Bus is recessive unless dom is high
`default_nettype none
module cei_bus_node
#(
	parameter int BIT_CLKS = 2
)
(
	// Clock and reset
	input  wire logic clk,
	input  wire logic rst_n,
	// Bus control
	input  wire logic dom,
	// Bus view
	output logic      bit_tick,
	output logic      rx_pin,
	output logic      rec11_evt
);
	timeunit 1ns;
	timeprecision 1ps;
	int unsigned cnt_q;
	int unsigned run_q;
	wire         tick_w = (cnt_q == BIT_CLKS - 1);
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cnt_q     <= 0;
			run_q     <= 0;
			bit_tick  <= 1'b0;
			rec11_evt <= 1'b0;
		end
		else
		begin
			bit_tick  <= tick_w;
			cnt_q     <= tick_w ? 0 : cnt_q + 1;
			rec11_evt <= tick_w && !dom && run_q == 10;
			if (tick_w)
				run_q <= (dom || run_q == 10) ? 0 : run_q + 1;
		end
	end
	// Dominant is low on the wire
	assign rx_pin = !dom;
endmodule
`default_nettype wire

// ===== can_error_interrupt_logic_test.sv
// Purpose: Self-checking bench of the error and interrupt block
// Assumes: Register port answers reads one cycle later
// Notes:   Bit time of two clocks keeps the bus-off runs short
`include "cei_params.svh"
`default_nettype none
module can_error_interrupt_logic_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic              clk = 1'b0;
	logic              rst_n = 1'b0;
	cei_pkg::cei_req_t req = '0;
	logic [31:0]       rdata;
	logic [7:0]        ev = '0;
	logic [6:0]        be = '0;
	logic [3:0]        dlc = '0;
	logic [3:0]        rdl = '0;
	logic [6:0]        len = '0;
	logic [6:0]        bsz = '0;
	logic [8:0]        tec = '0;
	logic [8:0]        rec = '0;
	logic [9:0]        tm = '0;
	logic [9:0]        dc = '0;
	logic [2:0]        src = '0;
	logic              eq = 1'b0;
	logic              dom = 1'b0;
	logic              irg;
	logic              ice;
	logic              itx;
	logic              bo;
	logic              bt;
	logic              rp;
	logic              r11;
	cei_pkg::cei_mode_t md;
	cei_pkg::cei_rx_t   rx;
	int                failures = 0;
	int                n_compared = 0;
	int                cyc = 0;
	assign rx = {ev[7], dlc, rdl, len, bsz};
	cei_core cei_core_inst
	(
		.clk(clk), .rst_n(rst_n), .req(req), .rdata(rdata), .rx(rx),
		.fifo_full_store(ev[0]), .hist_full_store(ev[1]), .bus_err(be),
		.err_qualify(eq), .frame_done(ev[2]), .tec(tec), .rec(rec),
		.rec11_evt(r11), .bit_tick(bt), .rx_pin(rp), .overload(ev[3]),
		.arb_lost(ev[4]), .tdc_valid(ev[5]), .tdc_meas(tm), .dbit_clks(dc),
		.abort_done(ev[6]), .tx_done_irq(src[0]), .cf_tx_irq(src[1]),
		.hist_irq(src[2]), .irq_global(irg), .irq_chan_err(ice), .irq_tx(itx),
		.mode(md), .bus_off(bo)
	);
	cei_bus_node #(.BIT_CLKS(2)) cei_bus_node_inst
	(
		.clk(clk), .rst_n(rst_n), .dom(dom), .bit_tick(bt), .rx_pin(rp),
		.rec11_evt(r11)
	);
	always #2 clk = ~clk;
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 40000)
		begin
			failures++;
			conclude();
		end
	end
	////////////////////////////////////////////////////////////////////////////
	task automatic conclude();
		if (failures == 0 && n_compared > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e)
		begin
			failures++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk) req <= '{a, d, 1'b1, 1'b0};
		@(posedge clk) req <= '0;
	endtask
	task automatic exp(input string nm, input logic [7:0] a, input logic [31:0] e);
		@(posedge clk) req <= '{a, 32'h0000_0000, 1'b0, 1'b1};
		@(posedge clk) req <= '0;
		#1 chk(nm, e, rdata);
	endtask
	task automatic pulse(input logic [7:0] m, input logic [6:0] b);
		@(posedge clk) ev <= m;
		be <= b;
		@(posedge clk) ev <= '0;
		be <= '0;
	endtask
	////////////////////////////////////////////////////////////////////////////
	task automatic t_global();
		wr(`CEI_OFF_CTRL, 32'h0000_0040);
		@(posedge clk) dlc <= 4'h3;
		rdl <= 4'h5;
		len <= 7'h14;
		bsz <= 7'h08;
		pulse(8'h80, 7'h00);
		exp("gfl dlc", `CEI_OFF_GFL, 32'h0000_0001);
		wr(`CEI_OFF_GFL, 32'h0000_000F);
		@(posedge clk) dlc <= 4'h5;
		pulse(8'h83, 7'h00);
		exp("gfl all", `CEI_OFF_GFL, 32'h0000_000E);
		@(negedge clk) chk("irq_global", 32'h0, irg);
		wr(`CEI_OFF_GIE, 32'h0000_0004);
		@(negedge clk) chk("irq_global", 32'h1, irg);
		wr(`CEI_OFF_GFL, 32'h0000_0004);
		exp("gfl held", `CEI_OFF_GFL, 32'h0000_000A);
	endtask
	task automatic t_buserr();
		pulse(8'h00, 7'h05);
		pulse(8'h00, 7'h02);
		exp("cfl first", `CEI_OFF_CFL, 32'h0000_0501);
		@(negedge clk) chk("irq_chan_err", 32'h0, ice);
		wr(`CEI_OFF_CIE, 32'h0000_0001);
		@(negedge clk) chk("irq_chan_err", 32'h1, ice);
		wr(`CEI_OFF_CTRL, 32'h0000_0050);
		pulse(8'h00, 7'h02);
		exp("cfl every", `CEI_OFF_CFL, 32'h0000_0701);
		wr(`CEI_OFF_CFL, 32'h0000_0701);
	endtask
	task automatic t_chan();
		@(posedge clk) dc <= 10'h004;
		tm <= 10'h016;
		eq <= 1'b1;
		pulse(8'h38, 7'h00);
		exp("cfl ovl arb", `CEI_OFF_CFL, 32'h0000_00A0);
		@(posedge clk) tm <= 10'h017;
		pulse(8'h20, 7'h00);
		exp("cfl tdc", `CEI_OFF_CFL, 32'h0002_00A0);
		repeat (255) pulse(8'h04, 7'h01);
		exp("cnt", `CEI_OFF_CNT, 32'h0000_FFFF);
		pulse(8'h04, 7'h01);
		exp("cfl ovf", `CEI_OFF_CFL, 32'h0003_81A1);
		@(posedge clk) eq <= 1'b0;
	endtask
	task automatic t_tx();
		wr(`CEI_OFF_CTRL, 32'h0000_00D0);
		pulse(8'h40, 7'h00);
		exp("txf", `CEI_OFF_TXF, 32'h0000_0001);
		@(negedge clk) chk("irq_tx abort", 32'h1, itx);
		wr(`CEI_OFF_TXF, 32'h0000_0001);
		@(negedge clk) chk("irq_tx idle", 32'h0, itx);
		for (int i = 0; i < 3; i++)
		begin
			@(posedge clk) src <= 3'b001 << i;
			@(negedge clk) chk("irq_tx source", 32'h1, itx);
		end
		@(posedge clk) src <= 3'b000;
	endtask
	task automatic t_warn();
		wr(`CEI_OFF_CTRL, 32'h0000_0011);
		wr(`CEI_OFF_CTRL, 32'h0000_0010);
		wr(`CEI_OFF_CFL, 32'h0007_FFFF);
		@(posedge clk) tec <= 9'd95;
		exp("warn 95", `CEI_OFF_CFL, 32'h0000_0000);
		@(posedge clk) tec <= 9'd96;
		exp("warn 96", `CEI_OFF_CFL, 32'h0000_0002);
		wr(`CEI_OFF_CFL, 32'h0000_0002);
		@(posedge clk) tec <= 9'd0;
		@(posedge clk) rec <= 9'd128;
		exp("passive", `CEI_OFF_CFL, 32'h0000_0004);
		@(posedge clk) rec <= 9'd0;
	endtask
	task automatic t_lock();
		wr(`CEI_OFF_CFL, 32'h0007_FFFF);
		@(posedge clk) dom <= 1'b1;
		repeat (56) @(posedge clk);
		exp("lock early", `CEI_OFF_CFL, 32'h0000_0000);
		repeat (16) @(posedge clk);
		@(posedge clk) dom <= 1'b0;
		exp("lock", `CEI_OFF_CFL, 32'h0000_0040);
	endtask
	task automatic t_boff(input logic [1:0] bm, input logic [1:0] m_in, input logic [1:0] m_out,
		input logic rf);
		wr(`CEI_OFF_CTRL, 32'h0000_0011 | (bm << 2));
		wr(`CEI_OFF_CTRL, 32'h0000_0010 | (bm << 2));
		wr(`CEI_OFF_CFL, 32'h0007_FFFF);
		@(posedge clk) tec <= 9'd256;
		@(posedge clk) tec <= 9'd0;
		@(negedge clk) chk("bus_off", 32'h1, bo);
		chk("mode entry", m_in, md);
		repeat (2600) @(posedge clk);
		if (bm != 2'b01)
			chk("bus_off early", 32'h1, bo);
		for (int i = 0; i < 1400 && bo === 1'b1; i++)
			@(posedge clk);
		@(negedge clk) chk("mode end", m_out, md);
		exp("cfl recov", `CEI_OFF_CFL, {27'h0, rf, 4'hE});
		wr(`CEI_OFF_CTRL, 32'h0000_0011);
	endtask
	////////////////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		exp("ctrl reset", `CEI_OFF_CTRL, 32'h0000_0001);
		exp("unmapped", 8'h40, 32'h0000_0000);
		t_global();
		t_buserr();
		t_chan();
		t_tx();
		t_warn();
		t_lock();
		t_boff(2'b00, cei_pkg::CEI_MD_OP, cei_pkg::CEI_MD_OP, 1'b1);
		t_boff(2'b01, cei_pkg::CEI_MD_HALT, cei_pkg::CEI_MD_HALT, 1'b0);
		t_boff(2'b10, cei_pkg::CEI_MD_OP, cei_pkg::CEI_MD_HALT, 1'b1);
		t_boff(2'b11, cei_pkg::CEI_MD_OP, cei_pkg::CEI_MD_OP, 1'b1);
		conclude();
	end
endmodule
`default_nettype wire
